// ---- rtl/dqsu_pkg.sv ----
// Shared constants and types for the queue status update logic.
package dqsu_pkg;
  localparam int          NQ          = 4;
  localparam int          QW          = 2;
  localparam int          IW          = 16;
  localparam int          DW          = 64;
  localparam int          FDEPTH      = 4;
  // ****************************************
  // Register offsets and reset value
  // ****************************************
  localparam logic [11:0] CTX_BASE    = 12'h000;
  localparam logic [11:0] CTX_STRIDE  = 12'h008;
  localparam logic [11:0] CTX_HI_OFS  = 12'h004;
  localparam logic [11:0] CRD_BASE    = 12'h100;
  localparam logic [11:0] CRD_STRIDE  = 12'h004;
  localparam logic [11:0] GCFG_ADDR   = 12'h250;
  localparam logic [31:0] GCFG_RESET  = 32'h00000000;
  // ****************************************
  // Context field positions, context width, port id and interval base
  // ****************************************
  localparam int          ARM_BIT     = 16;
  localparam int          QEN_BIT     = 0;
  localparam int          FCRD_BIT    = 1;
  localparam int          BYP_BIT     = 2;
  localparam int          INTVL_BIT   = 3;
  localparam int          CHK_BIT     = 4;
  localparam int          WBK_BIT     = 5;
  localparam int          IRQEN_BIT   = 6;
  localparam int          ST_BIT      = 7;
  localparam int          DIR_BIT     = 8;
  localparam int          ERR_BIT     = 9;
  localparam int          HIW         = 10;
  localparam logic [2:0]  PORT_ID     = 3'h0;
  localparam logic [15:0] IVL_BASE    = 16'h0004;

  typedef struct packed {
    logic [QW-1:0] qid;
    logic          card_to_host;
    logic          bypass;
    logic          stream;
    logic          enabled;
    logic          error;
    logic          arm_flag;
    logic          invalidated;
    logic [2:0]    port;
    logic [IW-1:0] available_count;
  } dqsu_sts_t;
endpackage

// ---- rtl/dqsu_if.sv ----
// Link between the descriptor engine end and the user logic end.
`timescale 1ns/10ps
interface dqsu_if;
  import dqsu_pkg::*;
  logic               queue_status_valid;
  logic               queue_status_ready;
  dqsu_sts_t          queue_status_output;
  logic               crd_valid;
  logic               crd_ready;
  logic               crd_dir;
  logic [QW-1:0]      crd_qid;
  logic [IW-1:0]      crd_cnt;
  logic               bin_valid;
  logic               bin_ready;
  logic [QW-1:0]      bin_qid;
  logic [IW-1:0]      bin_cidx;
  logic               bin_sdi;
  logic               bin_mrkr;
  logic               bout_valid;
  logic [QW-1:0]      bout_qid;
  logic [DW-1:0]      bout_dsc;
  logic               bout_err;
  logic               mrk_valid;
  logic [QW-1:0]      mrk_qid;
  logic [IW-1:0]      mrk_cidx;
  modport dev (output queue_status_valid, queue_status_output, input queue_status_ready,
               input crd_valid, crd_dir, crd_qid, crd_cnt, output crd_ready,
               input bin_valid, bin_qid, bin_cidx, bin_sdi, bin_mrkr, output bin_ready,
               output bout_valid, bout_qid, bout_dsc, bout_err, mrk_valid, mrk_qid, mrk_cidx);
  modport usr (input queue_status_valid, queue_status_output, output queue_status_ready,
               output crd_valid, crd_dir, crd_qid, crd_cnt, input crd_ready,
               output bin_valid, bin_qid, bin_cidx, bin_sdi, bin_mrkr, input bin_ready,
               input bout_valid, bout_qid, bout_dsc, bout_err, mrk_valid, mrk_qid, mrk_cidx);
endinterface

// ---- rtl/dqsu_device.sv ----
// Descriptor engine end: contexts, credits, status events, writebacks and interrupts.
`timescale 1ns/10ps
module dqsu_device import dqsu_pkg::*; (
  input  wire logic          CLOCK_IN,          // Core clock
  input  wire logic          SRST_IN,           // Synchronous reset
  input  wire logic          PSEL_IN,           // APB select
  input  wire logic          PENABLE_IN,        // APB enable
  input  wire logic          PWRITE_IN,         // APB direction
  input  wire logic [11:0]   PADDR_IN,          // APB byte address
  input  wire logic [31:0]   PWDATA_IN,         // APB write data
  output logic      [31:0]   PRDATA_OUT,        // APB read data
  output logic               PREADY_OUT,        // APB ready
  output logic               PSLVERR_OUT,       // APB error
  output logic               FETCH_REQ_OUT,     // Fetch request pulse
  output logic      [QW-1:0] FETCH_QID_OUT,     // Fetch queue
  output logic      [IW-1:0] FETCH_IDX_OUT,     // Fetch descriptor index
  input  wire logic          FETCH_CPL_IN,      // Fetch completion pulse
  input  wire logic          FETCH_ERR_IN,      // Fetch failed
  input  wire logic [DW-1:0] FETCH_DSC_IN,      // Fetched descriptor
  output logic               INT_DSC_VALID_OUT, // Internal engine descriptor
  output logic      [QW-1:0] INT_DSC_QID_OUT,   // Internal queue
  output logic      [DW-1:0] INT_DSC_OUT,       // Internal descriptor
  output logic               INT_DSC_ERR_OUT,   // Internal descriptor invalid
  output logic               EXEC_VALID_OUT,    // Bypass descriptor to engine
  input  wire logic          EXEC_READY_IN,     // Engine accepts
  output logic      [QW-1:0] EXEC_QID_OUT,      // Queue
  output logic      [IW-1:0] EXEC_CIDX_OUT,     // Consumer index
  output logic               EXEC_SDI_OUT,      // Status request
  output logic               EXEC_MRKR_OUT,     // Marker request
  input  wire logic          DONE_VALID_IN,     // Transfer finished
  input  wire logic          DONE_ACK_IN,       // Write data acknowledged
  input  wire logic [QW-1:0] DONE_QID_IN,       // Queue
  input  wire logic [IW-1:0] DONE_CIDX_IN,      // Consumer index
  input  wire logic          DONE_SDI_IN,       // Status request
  input  wire logic          DONE_MRKR_IN,      // Marker request
  input  wire logic          DONE_ERR_IN,       // Execution error
  output logic               WB_VALID_OUT,      // Host writeback pulse
  output logic      [QW-1:0] WB_QID_OUT,        // Writeback queue
  output logic      [IW-1:0] WB_CIDX_OUT,       // Writeback index
  output logic               WB_ERR_OUT,        // Writeback error
  output logic               IRQ_VALID_OUT,     // Interrupt pulse
  output logic      [QW-1:0] IRQ_QID_OUT,       // Interrupt queue
  output logic      [IW-1:0] IRQ_CIDX_OUT,      // Interrupt index
  dqsu_if.dev                LINK               // User logic link
);
  // ****************************************
  // Storage
  // ****************************************
  logic [IW-1:0]  pidx [NQ];
  logic [IW-1:0]  fidx [NQ];
  logic [IW-1:0]  crd  [NQ];
  logic [IW-1:0]  p_avl[NQ];
  logic [HIW-1:0] hi   [NQ];
  logic [NQ-1:0]  arm, pend, errsent, p_upd, p_arm, p_inv;
  logic [NQ-1:0]  cplq, erq, wbq, irq_go, can_f, wlo, whi, rlo, rhi, rcr;
  logic [31:0]    gcfg;
  logic           busy;
  logic [QW-1:0]  busy_qid;
  dqsu_sts_t      fifo [FDEPTH];
  logic [1:0]     wp, rp;
  logic [2:0]     cnt;
  logic [QW-1:0]  push_sel, f_sel, pend_sel;
  logic           push_any, f_any, pend_any;
  dqsu_sts_t      push_d;

  wire            wr_en   = PSEL_IN && PENABLE_IN && PWRITE_IN;
  wire            rd_sel  = PSEL_IN && !PWRITE_IN;
  wire            full    = (cnt == 3'(FDEPTH));
  wire            push    = push_any && !full;
  wire            pop     = LINK.queue_status_valid && LINK.queue_status_ready;
  wire            issue   = f_any && !busy && !full;
  wire            cpl     = DONE_VALID_IN && DONE_ACK_IN;
  wire            crd_tk  = LINK.crd_valid;
  wire            ex_ld   = LINK.bin_valid && LINK.bin_ready;
  wire [IW-1:0]   ivl_msk = (IVL_BASE << gcfg[2:0]) - 16'h0001;
  wire            gsel    = PADDR_IN == GCFG_ADDR;
  wire            mapped  = gsel || (|rlo) || (|rhi) || (|rcr);

  assign LINK.crd_ready = 1'b1;
  assign PREADY_OUT     = 1'b1;
  assign PSLVERR_OUT    = PSEL_IN && PENABLE_IN && !mapped;

  // ****************************************
  // Per-queue context
  // ****************************************
  for (genvar q = 0; q < NQ; q++) begin : g_q
    localparam logic [11:0] A_LO = CTX_BASE + 12'(q) * CTX_STRIDE;
    localparam logic [11:0] A_CR = CRD_BASE + 12'(q) * CRD_STRIDE;
    wire           fcq   = FETCH_CPL_IN && busy && (busy_qid == QW'(q));
    wire           crq   = crd_tk && (LINK.crd_qid == QW'(q));
    wire           isq   = issue && (f_sel == QW'(q));
    wire           pushq = push && (push_sel == QW'(q));
    wire           intv  = hi[q][INTVL_BIT] && ((DONE_CIDX_IN & ivl_msk) == 16'h0000);
    wire           chk   = hi[q][CHK_BIT] && (DONE_CIDX_IN == pidx[q]);
    wire           due   = DONE_ERR_IN || (hi[q][BYP_BIT] ? DONE_SDI_IN : (chk || intv));
    wire           irqd  = cplq[q] && due && hi[q][IRQEN_BIT] && !errsent[q];
    wire [IW-1:0]  dlt   = PWDATA_IN[IW-1:0] - pidx[q];
    wire           en    = hi[q][QEN_BIT];
    assign wlo[q]  = wr_en && (PADDR_IN == A_LO);
    assign whi[q]  = wr_en && (PADDR_IN == A_LO + CTX_HI_OFS);
    assign rlo[q]  = PADDR_IN == A_LO;
    assign rhi[q]  = PADDR_IN == A_LO + CTX_HI_OFS;
    assign rcr[q]  = PADDR_IN == A_CR;
    assign cplq[q] = cpl && (DONE_QID_IN == QW'(q));
    assign erq[q]  = (fcq && FETCH_ERR_IN) || (cplq[q] && DONE_ERR_IN);
    assign wbq[q]  = cplq[q] && due && hi[q][WBK_BIT] && !errsent[q];
    assign irq_go[q] = arm[q] && (irqd || (!cpl && pend_any && pend_sel == QW'(q)));
    assign can_f[q]  = en && !hi[q][ERR_BIT] && (fidx[q] != pidx[q]) && (!hi[q][FCRD_BIT] || crd[q] != 16'h0000);
    always_ff @(posedge CLOCK_IN) begin
      if (SRST_IN) begin
        pidx[q] <= '0; fidx[q] <= '0; crd[q] <= '0; p_avl[q] <= '0; hi[q] <= '0;
        arm[q] <= 1'b0; pend[q] <= 1'b0; errsent[q] <= 1'b0;
        p_upd[q] <= 1'b0; p_arm[q] <= 1'b0; p_inv[q] <= 1'b0;
      end else begin
        if (wlo[q]) pidx[q] <= PWDATA_IN[IW-1:0];
        if (isq) fidx[q] <= fidx[q] + 16'h0001;
        if (whi[q] && PWDATA_IN[QEN_BIT] && !en) fidx[q] <= pidx[q];
        crd[q] <= crd[q] + (crq ? LINK.crd_cnt : 16'h0000) - ((isq && hi[q][FCRD_BIT]) ? 16'h0001 : 16'h0000);
        if (pushq && p_inv[q] && !en) crd[q] <= crq ? LINK.crd_cnt : 16'h0000;
        if (irq_go[q]) arm[q] <= 1'b0;
        if (wlo[q]) arm[q] <= PWDATA_IN[ARM_BIT];
        if (irq_go[q]) pend[q] <= 1'b0;
        if (irqd && !arm[q]) pend[q] <= 1'b1;
        if (whi[q]) hi[q] <= PWDATA_IN[HIW-1:0];
        if (erq[q]) begin
          hi[q][QEN_BIT] <= 1'b0;
          hi[q][ERR_BIT] <= 1'b1;
        end
        if (whi[q] && !PWDATA_IN[ERR_BIT]) errsent[q] <= 1'b0;
        if (cplq[q] && erq[q]) errsent[q] <= 1'b1;
        if (pushq) begin
          p_upd[q] <= 1'b0; p_arm[q] <= 1'b0; p_inv[q] <= 1'b0;
        end
        p_avl[q] <= (pushq ? 16'h0000 : p_avl[q]) + ((wlo[q] && en) ? dlt : 16'h0000);
        if (wlo[q] && en && dlt != 16'h0000) p_upd[q] <= 1'b1;
        if (wlo[q] && en && PWDATA_IN[ARM_BIT] && !arm[q]) begin
          p_arm[q] <= 1'b1;
          p_upd[q] <= 1'b1;
        end
        if ((erq[q] && en) || (whi[q] && en && !PWDATA_IN[QEN_BIT]) || (crq && !en)) begin
          p_inv[q] <= 1'b1;
          p_upd[q] <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Arbitration and status event
  // ****************************************
  always_comb begin
    push_any = 1'b0; push_sel = '0; f_any = 1'b0; f_sel = '0; pend_any = 1'b0; pend_sel = '0;
    for (int i = NQ - 1; i >= 0; i--) begin
      if (p_upd[i]) begin
        push_any = 1'b1;
        push_sel = QW'(i);
      end
      if (can_f[i]) begin
        f_any = 1'b1;
        f_sel = QW'(i);
      end
      if (pend[i] && arm[i]) begin
        pend_any = 1'b1;
        pend_sel = QW'(i);
      end
    end
  end

  assign push_d = '{qid: push_sel, card_to_host: hi[push_sel][DIR_BIT], bypass: hi[push_sel][BYP_BIT],
                    stream: hi[push_sel][ST_BIT], enabled: hi[push_sel][QEN_BIT],
                    error: hi[push_sel][ERR_BIT], arm_flag: p_arm[push_sel],
                    invalidated: p_inv[push_sel], port: PORT_ID,
                    available_count: p_inv[push_sel] ? crd[push_sel] : p_avl[push_sel]};
  assign LINK.queue_status_valid  = cnt != 3'h0;
  assign LINK.queue_status_output = fifo[rp];
  assign LINK.bin_ready           = !EXEC_VALID_OUT || EXEC_READY_IN;

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      wp <= '0; rp <= '0; cnt <= '0;
    end else begin
      if (push) fifo[wp] <= push_d;
      wp  <= wp + 2'(push);
      rp  <= rp + 2'(pop);
      cnt <= cnt + 3'(push) - 3'(pop);
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) gcfg <= GCFG_RESET;
    else if (wr_en && gsel) gcfg <= PWDATA_IN;
  end

  always_comb begin
    PRDATA_OUT = 32'h00000000;
    if (rd_sel && gsel) PRDATA_OUT = gcfg;
    for (int i = 0; i < NQ; i++) begin
      if (rd_sel && rlo[i]) PRDATA_OUT = {15'h0000, arm[i], pidx[i]};
      if (rd_sel && rhi[i]) PRDATA_OUT = {22'h000000, hi[i]};
      if (rd_sel && rcr[i]) PRDATA_OUT = {fidx[i], crd[i]};
    end
  end

  // ****************************************
  // Fetch, delivery and completion outputs
  // ****************************************
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      busy <= 1'b0; busy_qid <= '0; FETCH_REQ_OUT <= 1'b0; FETCH_QID_OUT <= '0; FETCH_IDX_OUT <= '0;
      INT_DSC_VALID_OUT <= 1'b0; INT_DSC_QID_OUT <= '0; INT_DSC_OUT <= '0; INT_DSC_ERR_OUT <= 1'b0;
      LINK.bout_valid <= 1'b0; LINK.bout_qid <= '0; LINK.bout_dsc <= '0; LINK.bout_err <= 1'b0;
      EXEC_VALID_OUT <= 1'b0; EXEC_QID_OUT <= '0; EXEC_CIDX_OUT <= '0; EXEC_SDI_OUT <= 1'b0;
      EXEC_MRKR_OUT <= 1'b0; WB_VALID_OUT <= 1'b0; WB_QID_OUT <= '0; WB_CIDX_OUT <= '0; WB_ERR_OUT <= 1'b0;
      IRQ_VALID_OUT <= 1'b0; IRQ_QID_OUT <= '0; IRQ_CIDX_OUT <= '0;
      LINK.mrk_valid <= 1'b0; LINK.mrk_qid <= '0; LINK.mrk_cidx <= '0;
    end else begin
      FETCH_REQ_OUT <= issue;
      if (issue) begin
        busy <= 1'b1; busy_qid <= f_sel; FETCH_QID_OUT <= f_sel; FETCH_IDX_OUT <= fidx[f_sel];
      end else if (FETCH_CPL_IN) busy <= 1'b0;
      INT_DSC_VALID_OUT <= FETCH_CPL_IN && busy && !hi[busy_qid][BYP_BIT];
      LINK.bout_valid   <= FETCH_CPL_IN && busy && hi[busy_qid][BYP_BIT];
      if (FETCH_CPL_IN) begin
        INT_DSC_QID_OUT <= busy_qid; INT_DSC_OUT <= FETCH_DSC_IN; INT_DSC_ERR_OUT <= FETCH_ERR_IN;
        LINK.bout_qid <= busy_qid; LINK.bout_dsc <= FETCH_DSC_IN; LINK.bout_err <= FETCH_ERR_IN;
      end
      if (ex_ld) begin
        EXEC_VALID_OUT <= 1'b1; EXEC_QID_OUT <= LINK.bin_qid; EXEC_CIDX_OUT <= LINK.bin_cidx;
        EXEC_SDI_OUT <= LINK.bin_sdi; EXEC_MRKR_OUT <= LINK.bin_mrkr;
      end else if (EXEC_READY_IN) EXEC_VALID_OUT <= 1'b0;
      WB_VALID_OUT <= |wbq;
      WB_QID_OUT   <= DONE_QID_IN;
      WB_CIDX_OUT  <= DONE_CIDX_IN;
      WB_ERR_OUT   <= DONE_ERR_IN;
      IRQ_VALID_OUT <= |irq_go;
      IRQ_QID_OUT   <= cpl ? DONE_QID_IN : pend_sel;
      IRQ_CIDX_OUT  <= cpl ? DONE_CIDX_IN : pidx[pend_sel];
      LINK.mrk_valid <= cpl && DONE_MRKR_IN && !(errsent[DONE_QID_IN] && !hi[DONE_QID_IN][BYP_BIT]);
      LINK.mrk_qid   <= DONE_QID_IN;
      LINK.mrk_cidx  <= DONE_CIDX_IN;
    end
  end
endmodule // dqsu_device

// ---- rtl/dqsu_user.sv ----
// User logic end: credit and bypass descriptor sources, status and marker sinks.
`timescale 1ns/10ps
module dqsu_user import dqsu_pkg::*; (
  input  wire logic          CLOCK_IN,       // Core clock
  input  wire logic          SRST_IN,        // Synchronous reset
  input  wire logic [NQ-1:0] OWN_DSC_IN,     // Queue fed with own descriptors
  input  wire logic [NQ-1:0] IRQ_MODE_IN,    // Queue has interrupts enabled
  input  wire logic          CRD_VALID_IN,   // Credit request
  output logic               CRD_READY_OUT,  // Credit taken
  input  wire logic          CRD_DIR_IN,     // Credit direction
  input  wire logic [QW-1:0] CRD_QID_IN,     // Credit queue
  input  wire logic [IW-1:0] CRD_CNT_IN,     // Credit count
  input  wire logic          DSC_VALID_IN,   // Descriptor request
  output logic               DSC_READY_OUT,  // Descriptor taken
  input  wire logic [QW-1:0] DSC_QID_IN,     // Descriptor queue
  input  wire logic [IW-1:0] DSC_CIDX_IN,    // Consumer index
  input  wire logic          DSC_SDI_IN,     // Status request
  input  wire logic          DSC_MRKR_IN,    // Marker request
  output logic               STS_VALID_OUT,  // Status event pulse
  output dqsu_sts_t          STS_OUT,        // Status event
  output logic               MRK_VALID_OUT,  // Marker pulse
  output logic      [QW-1:0] MRK_QID_OUT,    // Marker queue
  output logic      [IW-1:0] MRK_CIDX_OUT,   // Marker index
  output logic               BYP_VALID_OUT,  // Fetched descriptor pulse
  output logic      [QW-1:0] BYP_QID_OUT,    // Fetched queue
  output logic      [DW-1:0] BYP_DSC_OUT,    // Fetched descriptor
  output logic               BYP_ERR_OUT,    // Fetched descriptor invalid
  output logic      [NQ-1:0] ARM_SEEN_OUT,   // Arm indication held
  dqsu_if.usr                LINK            // Engine link
);
  wire blocked = DSC_SDI_IN && IRQ_MODE_IN[DSC_QID_IN] && !ARM_SEEN_OUT[DSC_QID_IN];
  wire crd_drop = OWN_DSC_IN[CRD_QID_IN];
  wire crd_tk   = CRD_VALID_IN && CRD_READY_OUT && !crd_drop;
  wire dsc_tk   = DSC_VALID_IN && DSC_READY_OUT;
  wire arm_ev   = LINK.queue_status_valid && LINK.queue_status_output.arm_flag;

  assign LINK.queue_status_ready = 1'b1;
  assign CRD_READY_OUT = !LINK.crd_valid || LINK.crd_ready;
  assign DSC_READY_OUT = (!LINK.bin_valid || LINK.bin_ready) && !blocked;

  // ****************************************
  // Per-queue arm tracking
  // ****************************************
  for (genvar q = 0; q < NQ; q++) begin : g_arm
    always_ff @(posedge CLOCK_IN) begin
      if (SRST_IN) ARM_SEEN_OUT[q] <= 1'b0;
      else if (arm_ev && LINK.queue_status_output.qid == QW'(q)) ARM_SEEN_OUT[q] <= 1'b1;
      else if (dsc_tk && DSC_SDI_IN && DSC_QID_IN == QW'(q)) ARM_SEEN_OUT[q] <= 1'b0;
    end
  end

  // ****************************************
  // Link registers and mirrors
  // ****************************************
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      LINK.crd_valid <= 1'b0; LINK.crd_dir <= 1'b0; LINK.crd_qid <= '0; LINK.crd_cnt <= '0;
      LINK.bin_valid <= 1'b0; LINK.bin_qid <= '0; LINK.bin_cidx <= '0; LINK.bin_sdi <= 1'b0;
      LINK.bin_mrkr <= 1'b0; STS_VALID_OUT <= 1'b0; STS_OUT <= '0; MRK_VALID_OUT <= 1'b0;
      MRK_QID_OUT <= '0; MRK_CIDX_OUT <= '0; BYP_VALID_OUT <= 1'b0; BYP_QID_OUT <= '0;
      BYP_DSC_OUT <= '0; BYP_ERR_OUT <= 1'b0;
    end else begin
      if (crd_tk) begin
        LINK.crd_valid <= 1'b1; LINK.crd_dir <= CRD_DIR_IN; LINK.crd_qid <= CRD_QID_IN; LINK.crd_cnt <= CRD_CNT_IN;
      end else if (LINK.crd_ready) LINK.crd_valid <= 1'b0;
      if (dsc_tk) begin
        LINK.bin_valid <= 1'b1; LINK.bin_qid <= DSC_QID_IN; LINK.bin_cidx <= DSC_CIDX_IN;
        LINK.bin_sdi <= DSC_SDI_IN; LINK.bin_mrkr <= DSC_MRKR_IN;
      end else if (LINK.bin_ready) LINK.bin_valid <= 1'b0;
      STS_VALID_OUT <= LINK.queue_status_valid;
      if (LINK.queue_status_valid) STS_OUT <= LINK.queue_status_output;
      MRK_VALID_OUT <= LINK.mrk_valid;
      MRK_QID_OUT   <= LINK.mrk_qid;
      MRK_CIDX_OUT  <= LINK.mrk_cidx;
      BYP_VALID_OUT <= LINK.bout_valid;
      BYP_QID_OUT   <= LINK.bout_qid;
      BYP_DSC_OUT   <= LINK.bout_dsc;
      BYP_ERR_OUT   <= LINK.bout_err;
    end
  end
endmodule // dqsu_user

// ---- sim/dqsu_asserts.sv ----
// Concurrent checks on the status, bypass and marker lines between the two ends.
`timescale 1ns/10ps
module dqsu_asserts import dqsu_pkg::*; (
  input wire logic      CLOCK_IN,            // Core clock
  input wire logic      SRST_IN,             // Synchronous reset
  input wire logic      queue_status_valid,  // Status valid
  input wire logic      queue_status_ready,  // Status ready
  input wire dqsu_sts_t queue_status_output, // Status event
  input wire logic      bout_valid,          // Bypass out pulse
  input wire logic      mrk_valid            // Marker pulse
);
  // ****************************************
  // Link properties
  // ****************************************
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  chk_sts_not_stalled: assert property (queue_status_valid |-> queue_status_ready)
    else $error("status stalled");
  chk_sts_port_id: assert property (queue_status_valid |-> queue_status_output.port == PORT_ID)
    else $error("bad port id");
  chk_inv_disabled: assert property (queue_status_valid && queue_status_output.invalidated
    |-> !queue_status_output.enabled) else $error("invalidated yet enabled");
  chk_err_invalidates: assert property (queue_status_valid && queue_status_output.error
    |-> queue_status_output.invalidated) else $error("error without invalidation");
  chk_enabled_no_err: assert property (queue_status_valid && queue_status_output.enabled
    |-> !queue_status_output.error) else $error("enabled queue with error");
  chk_arm_on_enabled: assert property (queue_status_valid && queue_status_output.arm_flag
    |-> queue_status_output.enabled) else $error("arm flag on disabled queue");
  chk_bout_one_fetch: assert property (bout_valid |=> !bout_valid)
    else $error("bypass out back to back");
  chk_reset_quiet: assert property ($fell(SRST_IN) |-> !queue_status_valid && !bout_valid && !mrk_valid)
    else $error("event right after reset");
  cov_arm: cover property (queue_status_valid && queue_status_output.arm_flag);
  cov_inv: cover property (queue_status_valid && queue_status_output.invalidated);
  cov_mrk: cover property (mrk_valid);
endmodule // dqsu_asserts

// ---- sim/tb_top.sv ----
// Testbench joining both ends over the link.
`timescale 1ns/10ps
module tb_top import dqsu_pkg::*;;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, fcpl = 0, ferr = 0, dv = 0, ack = 0, sdi = 0;
  logic        cv = 0, dsv = 0, rdy = 0, prdy, perr, e, wbv, irv, exv, stv, mkv, bpv, bpe;
  logic [3:0]  irqm = 0, arm;
  logic [1:0]  dq = 0;
  logic [11:0] pa = 0;
  logic [15:0] ci = 0, cc = 0, fidx, wbc, irc, mkc;
  logic [31:0] pwd = 0, prd, r;
  logic [63:0] fdsc = 0, bpd;
  dqsu_sts_t   sts;
  int          n_fail = 0, compares = 0;
  wire  [7:0]  ev = {irv, prdy, fidx[0], stv, bpv, wbv, mkv, exv};
  dqsu_if      lnk ();
  dqsu_device i_dqsu_device (.CLOCK_IN(clk), .SRST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .FETCH_REQ_OUT(),
    .FETCH_QID_OUT(), .FETCH_IDX_OUT(fidx), .FETCH_CPL_IN(fcpl), .FETCH_ERR_IN(ferr), .FETCH_DSC_IN(fdsc),
    .INT_DSC_VALID_OUT(), .INT_DSC_QID_OUT(), .INT_DSC_OUT(), .INT_DSC_ERR_OUT(), .EXEC_VALID_OUT(exv),
    .EXEC_READY_IN(rdy), .EXEC_QID_OUT(), .EXEC_CIDX_OUT(), .EXEC_SDI_OUT(), .EXEC_MRKR_OUT(), .DONE_VALID_IN(dv),
    .DONE_ACK_IN(ack), .DONE_QID_IN(dq), .DONE_CIDX_IN(ci), .DONE_SDI_IN(sdi), .DONE_MRKR_IN(sdi),
    .DONE_ERR_IN(1'b0), .WB_VALID_OUT(wbv), .WB_QID_OUT(), .WB_CIDX_OUT(wbc), .WB_ERR_OUT(),
    .IRQ_VALID_OUT(irv), .IRQ_QID_OUT(), .IRQ_CIDX_OUT(irc), .LINK(lnk));
  dqsu_user i_dqsu_user (.CLOCK_IN(clk), .SRST_IN(rst), .OWN_DSC_IN(4'h0), .IRQ_MODE_IN(irqm), .CRD_VALID_IN(cv),
    .CRD_READY_OUT(), .CRD_DIR_IN(1'b0), .CRD_QID_IN(ci[1:0]), .CRD_CNT_IN(cc), .DSC_VALID_IN(dsv),
    .DSC_READY_OUT(), .DSC_QID_IN(2'h0), .DSC_CIDX_IN(ci), .DSC_SDI_IN(sdi), .DSC_MRKR_IN(sdi),
    .STS_VALID_OUT(stv), .STS_OUT(sts), .MRK_VALID_OUT(mkv), .MRK_QID_OUT(), .MRK_CIDX_OUT(mkc),
    .BYP_VALID_OUT(bpv), .BYP_QID_OUT(), .BYP_DSC_OUT(bpd), .BYP_ERR_OUT(bpe), .ARM_SEEN_OUT(arm), .LINK(lnk));
  dqsu_asserts i_dqsu_asserts (.CLOCK_IN(clk), .SRST_IN(rst), .queue_status_valid(lnk.queue_status_valid),
    .queue_status_ready(lnk.queue_status_ready), .queue_status_output(lnk.queue_status_output),
    .bout_valid(lnk.bout_valid), .mrk_valid(lnk.mrk_valid));
  // ****************************************
  // Helpers
  // ****************************************
  always #10 clk = ~clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Waits a bounded time for one event line to be high at a rising edge.
  task automatic wait_ev(input int k);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ev[k] !== 1'b1 && i < 200);
    if (ev[k] !== 1'b1) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    wait_ev(6);
    r = prd;
    e = perr;
    {psel, pen} <= 2'h0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, GCFG_ADDR, 32'h0);
    chk(r, GCFG_RESET);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({e, r}, 33'h100000000);
    apb(1'b1, CTX_BASE + CTX_HI_OFS, 32'h00000065);
    apb(1'b1, CTX_BASE, 32'h00010002);
    wait_ev(4);
    chk(sts, 28'h1500002);
    $display("status test done");
    irqm <= 4'h1;
    @(posedge clk);
    chk(arm, 4'h1);
    {dsv, sdi, ci} <= {1'b1, 1'b1, 16'h0005};
    @(posedge clk);
    dsv <= 1'b0;
    wait_ev(0);
    rdy <= 1'b1;
    @(posedge clk);
    rdy <= 1'b0;
    chk(arm, 4'h0);
    {dv, ack} <= 2'h3;
    @(posedge clk);
    {dv, ack} <= 2'h0;
    wait_ev(2);
    chk({wbc, irc, 15'h0, irv}, {16'h0005, 16'h0005, 16'h0001});
    wait_ev(1);
    chk(mkc, 16'h0005);
    apb(1'b0, CTX_BASE, 32'h0);
    chk(r, 32'h00000002);
    $display("bypass test done");
    chk(fidx, 16'h0000);
    {fdsc, fcpl} <= {64'h0123456789ABCDEF, 1'b1};
    @(posedge clk);
    fcpl <= 1'b0;
    wait_ev(3);
    chk({bpe, bpd[62:0]}, 64'h0123456789ABCDEF);
    wait_ev(5);
    {ferr, fcpl} <= 2'h3;
    @(posedge clk);
    {ferr, fcpl} <= 2'h0;
    wait_ev(3);
    chk(bpe, 1'b1);
    wait_ev(4);
    chk(sts, 28'h1280000);
    $display("error test done");
    {cc, cv} <= {16'h0007, 1'b1};
    @(posedge clk);
    cv <= 1'b0;
    wait_ev(4);
    chk(sts, 28'h4080007);
    $display("credit test done");
    apb(1'b1, 12'h014, 32'h00000051);
    apb(1'b1, 12'h010, 32'h00000001);
    {dq, ci, dv, ack} <= {2'h2, 16'h0001, 2'h3};
    @(posedge clk);
    {dv, ack} <= 2'h0;
    repeat (3) @(posedge clk);
    chk(irv, 1'b0);
    apb(1'b1, 12'h010, 32'h00010001);
    wait_ev(7);
    chk(irc, 16'h0001);
    apb(1'b0, 12'h010, 32'h0);
    chk(r, 32'h00000001);
    $display("interrupt test done");
    summarize();
  end
endmodule // tb_top
